/* hdl/lsd_cfg.svh */
// Constants for the serial LCD segment shift/latch driver.
// Assumes inclusion by its bare name from the driver and the bench.
`ifndef LSD_CFG_SVH
`define LSD_CFG_SVH

// Display geometry
`define LSD_SEG_N        60
`define LSD_WORD_W       32
`define LSD_DATA_W       128

// Core clock rate and internal common half period
`define LSD_CLK_MHZ      25
`define LSD_COM_HALF_US  5000
`define LSD_COM_HALF_CYC (`LSD_COM_HALF_US * `LSD_CLK_MHZ)

// APB register byte addresses
`define LSD_A_CTRL       8'h00
`define LSD_A_STATUS     8'h04
`define LSD_A_DATA0      8'h08
`define LSD_A_DATA3      8'h14

// Control register field
`define LSD_CTRL_BLANK   0

// Status register fields
`define LSD_ST_VALID     0
`define LSD_ST_DYN       1
`define LSD_ST_EXT       2
`define LSD_ST_PH_LO     3
`define LSD_ST_SYNC      5
`define LSD_ST_TEST      6
`define LSD_ST_BLANKN    7

`endif

/* hdl/lsd_pkg.sv */
// Types shared by the LCD segment driver.
// Assumes lsd_cfg.svh is on the include path.
package lsd_pkg;

  // Pin levels sampled from outside the core clock domain
  typedef struct packed {
    logic mode_dyn;    // High selects half duty dynamic mode
    logic src_ext;     // High selects the external common source
    logic test_on;     // All-on test level
    logic blank_n;     // All-off level, active low
    logic osc;         // Oscillator / external common input
    logic sync;        // Shared sync line level
    logic load;        // Latch strobe
  } lsd_pins_t;

  // Common phase within a dynamic cycle pair
  typedef enum logic [1:0] {
    LSD_PH_A0,
    LSD_PH_A1,
    LSD_PH_B0,
    LSD_PH_B1
  } lsd_phase_t;

endpackage : lsd_pkg

/* hdl/lsd_driver.sv */
// Serial-in LCD segment driver: shift register, latch, common generator,
// override inputs, cascade outputs, sync line and an APB register slave.
// Assumes the host stops shift_clk while load is high, so the shift
// register is stable whenever the core domain copies it.
//
// Summary of operation
// [RQ1] High data bit lights its segment, one-to-one
// [RQ2] Serial data shifts in on shift clock rise
// [RQ3] Latch follows shift data while load high
// [RQ4] All-off low blanks; release restores latched data
// [RQ5] Test high lights all; release restores data
// [RQ6] Test high overrides the all-off input
// [RQ7] Mode high is half duty, low static
// [RQ8] Source high uses oscillator input as common
// [RQ9] Source low uses internal common oscillator
// [RQ10] Expander: oscillator input high inverts outputs
// [RQ11] Pulled-up sync line aligns dynamic common phase
// [RQ12] System grounds sync in static or expander use
// [RQ13] First cascade output is shift stage 60
// [RQ14] Second cascade output is shift stage 120
// [RQ15] Master common out feeds every slave oscillator
// [RQ16] Static commons in phase; dynamic alternate select
// [RQ17] Contents undefined until first full load
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "lsd_cfg.svh"

module lsd_driver #(
  parameter int SEG_N        = `LSD_SEG_N,        // Segment outputs
  parameter int COM_HALF_CYC = `LSD_COM_HALF_CYC  // Internal common half
) (
  input  wire logic             core_clk,            // Core clock
  input  wire logic             resetn,              // Sync reset, low
  // APB slave
  input  wire logic             psel,                // Select
  input  wire logic             penable,             // Access phase
  input  wire logic             pwrite,              // Write direction
  input  wire logic [7:0]       paddr,               // Byte address
  input  wire logic [31:0]      pwdata,              // Write data
  input  wire logic [3:0]       pstrb,               // Byte strobes
  output logic                  pready,              // Transfer done
  output logic [31:0]           prdata,              // Read data
  output logic                  pslverr,             // Unmapped access
  // Serial link, own clock domain
  input  wire logic             shift_clk,           // Shift clock
  input  wire logic             serial_in,           // Serial data
  output logic                  cascade_out_static,  // Stage 60
  output logic                  cascade_out_dynamic, // Stage 120
  // Control pins
  input  wire logic             load,                // Latch strobe
  input  wire logic             blank_n,             // All-off, low
  input  wire logic             all_on_test,         // All-on test
  input  wire logic             mode_select,         // High dynamic
  input  wire logic             common_source_select, // High external
  input  wire logic             osc_input,           // Osc / ext common
  output logic                  osc_drive,           // Internal osc_drive
  // Sync line, open drain
  input  wire logic             sync_in,             // Line level
  output logic                  sync_out,            // Driven level
  output logic                  sync_oe,             // Pulls line low
  // Display outputs
  output logic                  common_buffered_out, // Buffered common
  output logic                  common_drive_a,      // Common A level
  output logic                  common_drive_b,      // Common B level
  output logic                  common_select_a,     // A select phase
  output logic                  common_select_b,     // B select phase
  output logic [SEG_N-1:0]      segment_outputs      // Segment levels
);

  ////////////////////////////////////////////////////////////////////////
  // Parameter checks
  localparam int SR_N = 2 * SEG_N;  // Shift register stages

  // Latch must fit the four readable data words
  if (SR_N > `LSD_DATA_W || SEG_N < 1)
  begin : g_bad_seg
    $error("SEG_N out of range");
  end
  // Common half period needs at least one cycle
  if (COM_HALF_CYC < 1)
  begin : g_bad_com
    $error("COM_HALF_CYC must be positive");
  end

  ////////////////////////////////////////////////////////////////////////
  // Functions
  // Address decode: true for a mapped register
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == `LSD_A_CTRL) || (a == `LSD_A_STATUS) ||
               ((a >= `LSD_A_DATA0) && (a <= `LSD_A_DATA3) &&
                (a[1:0] == 2'h0));
  endfunction : addr_hit

  // Pick one 32-bit word of the padded latch
  function automatic logic [31:0] data_word(
    input logic [`LSD_DATA_W-1:0] d,
    input logic [1:0]             idx
  );
    data_word = d[idx*`LSD_WORD_W +: `LSD_WORD_W];
  endfunction : data_word

  ////////////////////////////////////////////////////////////////////////
  // Link domain: shift register
  logic [SR_N-1:0] shift_ff;  // Serial stages, bit 0 is stage 1

  // Shift one bit in per rising shift clock; no reset here
  always_ff @(posedge shift_clk)
  begin
    shift_ff <= {shift_ff[SR_N-2:0], serial_in};  // [RQ2]
  end

  // Cascade taps straight from the stage flip-flops
  assign cascade_out_static  = shift_ff[SEG_N-1];  // [RQ13]
  assign cascade_out_dynamic = shift_ff[SR_N-1];   // [RQ14]

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  lsd_pkg::lsd_pins_t pin_m_ff;  // First stage, read only by second
  lsd_pkg::lsd_pins_t pin_ff;    // Second stage, safe to use

  // Two flip-flops before any logic sees a pin; pins in field order
  always_ff @(posedge core_clk)
  begin
    pin_m_ff <= {mode_select, common_source_select, all_on_test, blank_n,
                 osc_input, sync_in, load};
    pin_ff   <= pin_m_ff;
  end

  ////////////////////////////////////////////////////////////////////////
  // Latch
  logic [SR_N-1:0] latch_ff;  // Display data, undefined until loaded
  logic            valid_ff;  // A load has happened since reset

  // Transparent while the strobe is high, holds when it is low
  always_ff @(posedge core_clk)
  begin
    if (pin_ff.load)
    begin
      latch_ff <= shift_ff;  // [RQ3]
    end
  end

  // Segments stay dark until the first load has filled the latch, unless the all-on test is high
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      valid_ff <= 1'b0;  // [RQ17]
    end
    else if (pin_ff.load)
    begin
      valid_ff <= 1'b1;  // [RQ17]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Common source
  logic [31:0] osc_cnt_ff;  // Internal oscillator divider
  logic        int_com_ff;  // Internal common square wave
  logic        com;         // Selected common level
  logic        com_ff;      // Registered common, also edge memory
  logic        com_edge;    // Common changed this cycle

  // Internal oscillator: toggles every half period
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      osc_cnt_ff <= 32'h0;
      int_com_ff <= 1'b0;
    end
    else if (osc_cnt_ff == 32'(COM_HALF_CYC - 1))
    begin
      osc_cnt_ff <= 32'h0;
      int_com_ff <= ~int_com_ff;  // [RQ9]
    end
    else
    begin
      osc_cnt_ff <= osc_cnt_ff + 32'h1;
    end
  end

  // External source takes the oscillator input as the common
  assign com = pin_ff.src_ext ? pin_ff.osc : int_com_ff;  // [RQ8] [RQ9]

  // The registered common doubles as the level one cycle ago
  assign com_edge = com ^ com_ff;

  ////////////////////////////////////////////////////////////////////////
  // Dynamic phase and sync line
  lsd_pkg::lsd_phase_t phase_ff;  // Current common phase
  logic                sync_oe_ff; // Pulling the sync line low

  // Phase steps on each common edge; leaving B waits for the line
  always_ff @(posedge core_clk)
  begin
    if (!resetn || !pin_ff.mode_dyn)
    begin
      phase_ff <= lsd_pkg::LSD_PH_A0;  // [RQ7] static stays in A
    end
    else if (com_edge)
    begin
      unique case (phase_ff)
        lsd_pkg::LSD_PH_A0: phase_ff <= lsd_pkg::LSD_PH_A1;
        lsd_pkg::LSD_PH_A1: phase_ff <= lsd_pkg::LSD_PH_B0;
        lsd_pkg::LSD_PH_B0: phase_ff <= lsd_pkg::LSD_PH_B1;
        lsd_pkg::LSD_PH_B1:
        begin
          // Every chip must have released the line first
          if (pin_ff.sync)
          begin
            phase_ff <= lsd_pkg::LSD_PH_A0;  // [RQ11]
          end
        end
      endcase
    end
  end

  // Pull the line low during the first half of phase B only
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      sync_oe_ff <= 1'b0;
    end
    else
    begin
      // Static use leaves the grounded line alone; mode_dyn and phase B0 together gate the pull
      sync_oe_ff <= pin_ff.mode_dyn &&
                    (phase_ff == lsd_pkg::LSD_PH_B0);  // [RQ11] [RQ12]
    end
  end

  assign sync_oe  = sync_oe_ff;
  assign sync_out = 1'b0;  // Open drain: only ever drives low

  ////////////////////////////////////////////////////////////////////////
  // Segment and common outputs
  logic             in_b;        // Second half of a dynamic pair
  logic             blank_all;   // Any reason to blank
  logic [SEG_N-1:0] data_sel;    // Latched data for this phase
  logic [SEG_N-1:0] data_eff;    // Data after overrides
  logic [SEG_N-1:0] nxt_seg;     // Next segment levels
  logic [SEG_N-1:0] seg_ff;      // Registered segment levels
  logic             ctrl_blank_ff; // Software blank bit
  logic             common_drive_a_ff;    // Registered common A
  logic             common_drive_b_ff;    // Registered common B
  logic             sel_a_ff;    // Common A select
  logic             sel_b_ff;    // Common B select
  logic             osc_ff;      // Registered oscillator drive

  assign in_b = (phase_ff == lsd_pkg::LSD_PH_B0) ||
                (phase_ff == lsd_pkg::LSD_PH_B1);

  // Pick the latch half for the phase, then apply the overrides
  always_comb
  begin
    data_sel = in_b ? latch_ff[SR_N-1:SEG_N]
                    : latch_ff[SEG_N-1:0];  // [RQ7]
    blank_all = !pin_ff.blank_n || ctrl_blank_ff || !valid_ff;
    if (pin_ff.test_on)
    begin
      data_eff = '1;  // [RQ5] [RQ6] test beats blanking
    end
    else if (blank_all)
    begin
      data_eff = '0;  // [RQ4] latch left untouched
    end
    else
    begin
      data_eff = data_sel;  // [RQ1]
    end
    // Lit segment is driven against the common; unlit segment follows it
    nxt_seg = data_eff ^ {SEG_N{com}};  // [RQ1] [RQ10]
  end

  // Register every display output
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      seg_ff   <= '0;
      com_ff   <= 1'b0;
      common_drive_a_ff <= 1'b0;
      common_drive_b_ff <= 1'b0;
      sel_a_ff <= 1'b0;
      sel_b_ff <= 1'b0;
      osc_ff   <= 1'b0;
    end
    else
    begin
      seg_ff   <= nxt_seg;
      com_ff   <= com;       // [RQ8] buffered common
      osc_ff   <= int_com_ff;
      if (!pin_ff.mode_dyn)
      begin
        // Static: both commons pulse in phase with the common
        common_drive_a_ff <= com;     // [RQ16]
        common_drive_b_ff <= com;     // [RQ16]
        sel_a_ff <= 1'b1;
        sel_b_ff <= 1'b1;
      end
      else
      begin
        // Dynamic: A selects in phase A, B in phase B
        common_drive_a_ff <= in_b ? ~com : com;  // [RQ16]
        common_drive_b_ff <= in_b ? com : ~com;  // [RQ16]
        sel_a_ff <= !in_b;
        sel_b_ff <= in_b;
      end
    end
  end

  assign segment_outputs     = seg_ff;
  assign common_buffered_out = com_ff;  // [RQ15] feeds slave osc inputs
  assign common_drive_a      = common_drive_a_ff;
  assign common_drive_b      = common_drive_b_ff;
  assign common_select_a     = sel_a_ff;
  assign common_select_b     = sel_b_ff;
  assign osc_drive           = osc_ff;

  ////////////////////////////////////////////////////////////////////////
  // APB slave
  logic                   pready_ff;   // Completion
  logic [31:0]            prdata_ff;   // Read data
  logic                   pslverr_ff;  // Error answer
  logic                   access;      // Access phase, not yet done
  logic [`LSD_DATA_W-1:0] latch_pad;   // Latch padded to four words
  logic [31:0]            status;      // Live status word
  logic [31:0]            nxt_rdata;   // Read mux

  assign access = psel && penable && !pready_ff;

  // Answer one cycle into the access phase; read data stands with it
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end
    else
    begin
      pready_ff  <= access;
      pslverr_ff <= access && !addr_hit(paddr);
      prdata_ff  <= (access && !pwrite) ? nxt_rdata : 32'h0;
    end
  end

  // Software blank control, written at the edge that completes
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      ctrl_blank_ff <= 1'b0;
    end
    else if (psel && penable && pready_ff && pwrite && pstrb[0] &&
             paddr == `LSD_A_CTRL)
    begin
      ctrl_blank_ff <= pwdata[`LSD_CTRL_BLANK];
    end
  end

  // Status and read mux
  always_comb
  begin
    latch_pad = '0;
    latch_pad[SR_N-1:0] = valid_ff ? latch_ff : '0;
    status = 32'h0;
    status[`LSD_ST_VALID]  = valid_ff;
    status[`LSD_ST_DYN]    = pin_ff.mode_dyn;
    status[`LSD_ST_EXT]    = pin_ff.src_ext;
    status[`LSD_ST_PH_LO +: 2] = phase_ff;
    status[`LSD_ST_SYNC]   = pin_ff.sync;
    status[`LSD_ST_TEST]   = pin_ff.test_on;
    status[`LSD_ST_BLANKN] = pin_ff.blank_n;
    nxt_rdata = 32'h0;
    if (paddr == `LSD_A_CTRL)
    begin
      nxt_rdata[`LSD_CTRL_BLANK] = ctrl_blank_ff;
    end
    else if (paddr == `LSD_A_STATUS)
    begin
      nxt_rdata = status;
    end
    else if (addr_hit(paddr))
    begin
      nxt_rdata = data_word(latch_pad, 2'(paddr[7:2] - 6'h2));
    end
  end

  assign pready  = pready_ff;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff;

endmodule : lsd_driver

/* tb/lsd_driver_properties.sv */
// Assertions on the ports of the LCD segment driver.
// Assumes a synchronous active-low reset and the one-wait-state slave.
`timescale 1ns/1ps

module lsd_driver_properties #(
  parameter int SEG_N        = 60, // Segment outputs
  parameter int COM_HALF_CYC = 8   // Internal common half period
) (
  input wire logic             core_clk,             // Core clock
  input wire logic             resetn,               // Sync reset, low
  input wire logic             psel,                 // APB select
  input wire logic             penable,              // APB access
  input wire logic             pready,               // APB done
  input wire logic             pslverr,              // APB error
  input wire logic             all_on_test,          // All-on test
  input wire logic             blank_n,              // All-off, low
  input wire logic             mode_select,          // High dynamic
  input wire logic             common_source_select, // High external
  input wire logic             osc_input,            // External common
  input wire logic             sync_oe,              // Pulls sync low
  input wire logic             common_buffered_out,  // Buffered common
  input wire logic             common_drive_a,       // Common A level
  input wire logic             common_drive_b,       // Common B level
  input wire logic             common_select_a,      // A select phase
  input wire logic             common_select_b,      // B select phase
  input wire logic [SEG_N-1:0] segment_outputs       // Segment levels
);
  // All checks run on the core clock, quiet during reset
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////
  // Display overrides
  test_all_on_a: assert property (
    (all_on_test && $stable(common_buffered_out))[*6]
      |-> segment_outputs == {SEG_N{~common_buffered_out}})
    else $error("all-on test left a segment unlit");
  blank_all_off_a: assert property (
    (!blank_n && !all_on_test && $stable(common_buffered_out))[*6]
      |-> segment_outputs == {SEG_N{common_buffered_out}})
    else $error("all-off input left a segment lit");

  ////////////////////////////////////////////////////////////////////////
  // Common generation
  static_commons_a: assert property (
    (!mode_select && $stable(common_buffered_out))[*8]
      |-> common_drive_a == common_buffered_out
        && common_drive_b == common_buffered_out
        && common_select_a && common_select_b && !sync_oe)
    else $error("static commons not in phase with common");
  dyn_alternate_a: assert property (
    mode_select[*8] |-> common_select_a != common_select_b)
    else $error("dynamic commons select together");
  ext_common_a: assert property (
    (common_source_select && $stable(osc_input))[*6]
      |-> common_buffered_out == osc_input)
    else $error("external common not passed to buffered output");

  ////////////////////////////////////////////////////////////////////////
  // Register slave handshake
  apb_wait_a: assert property ( // One wait state
    psel && penable && !pready |=> pready)
    else $error("slave did not answer after one wait state");
  apb_single_a: assert property ( // Answer stands one cycle
    pready |=> !pready)
    else $error("ready stood longer than one cycle");
  apb_error_a: assert property ( // Error only with an answer
    pslverr |-> pready && psel && penable)
    else $error("error flag outside an access");

endmodule : lsd_driver_properties

bind lsd_driver lsd_driver_properties #(
  .SEG_N(SEG_N), .COM_HALF_CYC(COM_HALF_CYC)) u_props (
  .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .all_on_test(all_on_test),
  .blank_n(blank_n), .mode_select(mode_select),
  .common_source_select(common_source_select), .osc_input(osc_input),
  .sync_oe(sync_oe), .common_buffered_out(common_buffered_out),
  .common_drive_a(common_drive_a), .common_drive_b(common_drive_b),
  .common_select_a(common_select_a), .common_select_b(common_select_b),
  .segment_outputs(segment_outputs));

/* tb/lsd_host_model.sv */
// Host microcontroller: shifts a frame out on its own clock, then loads.
// Assumes the bench pulses start and waits for done.
`timescale 1ns/1ps

module lsd_host_model (
  input  wire logic         core_clk,  // Core clock, times the strobe
  input  wire logic         start,     // Begins one frame
  input  wire logic         slow,      // Stretches the gap between bits
  input  wire logic         do_load,   // Strobes the latch after shifting
  input  wire logic [119:0] frame,     // Bits, index is latch position
  output logic              shift_clk, // Link clock, still between frames
  output logic              serial_in, // Serial data
  output logic              load,      // Latch strobe
  output logic              done       // Frame finished
);
  // Idle levels
  initial
  begin
    shift_clk = 1'b0;
    serial_in = 1'b0;
    load      = 1'b0;
    done      = 1'b0;
  end

  // Last bit sent lands in stage 1, so send the top bit first
  always @(posedge start)
  begin
    done = 1'b0;
    #7;
    for (int i = 119; i >= 0; i--)
    begin
      serial_in = frame[i];
      #16 shift_clk = 1'b1;
      #16 shift_clk = 1'b0;
      if (slow)
        #64;
    end
    serial_in = ~frame[0];    // Released line does not keep the bit
    if (do_load)
    begin
      @(posedge core_clk);
      load <= 1'b1;
      repeat (8) @(posedge core_clk);
      load <= 1'b0;
    end
    repeat (4) @(posedge core_clk); // clock still until settled
    done <= 1'b1;
  end
endmodule : lsd_host_model

/* tb/tb_top.sv */
// Self-checking bench for the LCD segment driver.
// Assumes the driver, host model and bound checker are compiled.
`timescale 1ns/1ps
`include "lsd_cfg.svh"

module tb_top;
  logic         core_clk = 1'b0;  // Core clock
  logic         resetn   = 1'b0;  // Sync reset, low
  logic         psel     = 1'b0;  // APB select
  logic         penable  = 1'b0;  // APB access
  logic         pwrite   = 1'b0;  // APB direction
  logic [7:0]   paddr    = 8'h00; // APB address
  logic [31:0]  pwdata   = 32'h0; // APB write data
  logic [3:0]   pstrb    = 4'hf;  // APB strobes
  logic         pready, pslverr;  // APB answer
  logic [31:0]  prdata;           // APB read data
  logic         shift_clk, serial_in, load, cso, cdo; // Link
  logic         blank_n  = 1'b1;  // All-off, low
  logic         test     = 1'b0;  // All-on test
  logic         mode     = 1'b0;  // High dynamic
  logic         src      = 1'b1;  // High external common
  logic         osc      = 1'b0;  // Master common out
  logic         hold_low = 1'b1;  // Sync grounded by others
  logic         sync_out, sync_oe, osc_drive, cbo, cda, cdb, csa, csb;
  logic [59:0]  seg;              // Segment levels
  logic         start = 1'b0, slow = 1'b0, do_load = 1'b1, done;
  logic [119:0] frame = '0;       // Frame for the host
  logic [32:0]  exp_q[$];         // Expected {pslverr, prdata}
  int           errors = 0;       // Mismatches
  int           compares = 0;     // Comparisons
  // Pulled-up open-drain line
  wire          sync_in = sync_oe ? sync_out : ~hold_low;

  always #20 core_clk = ~core_clk;

  lsd_driver #(.SEG_N(60), .COM_HALF_CYC(8)) uut (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .shift_clk(shift_clk), .serial_in(serial_in),
    .cascade_out_static(cso), .cascade_out_dynamic(cdo), .load(load),
    .blank_n(blank_n), .all_on_test(test), .mode_select(mode),
    .common_source_select(src), .osc_input(osc), .osc_drive(osc_drive),
    .sync_in(sync_in), .sync_out(sync_out), .sync_oe(sync_oe),
    .common_buffered_out(cbo), .common_drive_a(cda),
    .common_drive_b(cdb), .common_select_a(csa), .common_select_b(csb),
    .segment_outputs(seg));

  lsd_host_model host (
    .core_clk(core_clk), .start(start), .slow(slow), .do_load(do_load),
    .frame(frame), .shift_clk(shift_clk), .serial_in(serial_in),
    .load(load), .done(done));

  ////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and helpers
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic conclude();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  // One APB transfer; the expected answer is queued for the monitor
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, input logic [32:0] exp);
    exp_q.push_back(exp);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  // Sends a frame through the host and checks the cascade stages
  task automatic send(input logic [119:0] d, input logic ld,
                      input logic sl);
    frame   <= d;
    do_load <= ld;
    slow    <= sl;
    start   <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    @(posedge core_clk);
    while (done !== 1'b1)
      @(posedge core_clk);
    check(cdo, d[119]);
    check(cso, d[59]);
  endtask : send

  // Expander: segments follow the latch, inverted while osc is high
  task automatic seg_chk(input logic [59:0] d);
    cyc(8);
    check(seg, d ^ {60{osc}});
  endtask : seg_chk

  // Takes the oldest expected answer whenever pready is sampled high
  always @(posedge core_clk)
  begin
    if (pready === 1'b1)
    begin
      if (exp_q.size() > 0)
        check({31'h0, pslverr, prdata}, {31'h0, exp_q.pop_front()});
      else
        check(64'h1, 64'h0);
    end
  end

  // Cuts a hang short
  initial
  begin
    repeat (20000) @(posedge core_clk);
    errors++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [119:0] d;
    void'($urandom(32'h4610));
    cyc(10);
    resetn <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, `LSD_A_CTRL, 32'h0, 33'h0);
    apb(1'b0, `LSD_A_STATUS, 32'h0, 33'h84);
    apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
    pstrb <= 4'he;
    apb(1'b1, `LSD_A_CTRL, 32'h1, 33'h0);
    pstrb <= 4'hf;
    apb(1'b1, `LSD_A_STATUS, 32'hff, 33'h0);
    apb(1'b0, `LSD_A_CTRL, 32'h0, 33'h0);
    check(seg, 64'h0);
    for (int r = 0; r < 3; r++)
    begin
      d = 120'({$urandom, $urandom, $urandom, $urandom});
      osc <= r[0];
      send(d, 1'b1, r[1]);
      for (int k = 0; k < 4; k++)
        apb(1'b0, `LSD_A_DATA0 + 8'(4 * k), 32'h0,
            {1'b0, 32'(d >> (32 * k))});
      seg_chk(d[59:0]);
    end
    send(~d, 1'b0, 1'b0);
    seg_chk(d[59:0]);
    apb(1'b0, `LSD_A_STATUS, 32'h0, 33'h85);
    // Overrides with the common high, so unlit reads as one
    osc     <= 1'b1;
    blank_n <= 1'b0;
    cyc(8);
    check(seg, {4'h0, {60{1'b1}}});
    test <= 1'b1;
    cyc(8);
    check(seg, 64'h0);
    test    <= 1'b0;
    blank_n <= 1'b1;
    seg_chk(d[59:0]);
    apb(1'b1, `LSD_A_CTRL, 32'h1, 33'h0);
    apb(1'b0, `LSD_A_CTRL, 32'h0, 33'h1);
    cyc(8);
    check(seg, {4'h0, {60{1'b1}}});
    apb(1'b1, `LSD_A_CTRL, 32'h0, 33'h0);
    // Internal common, static then dynamic on the pulled-up line
    src <= 1'b0;
    cyc(40);
    mode     <= 1'b1;
    hold_low <= 1'b0;
    cyc(100);
    hold_low <= 1'b1;
    cyc(100);
    apb(1'b0, `LSD_A_STATUS, 32'h0, 33'h9b);
    hold_low <= 1'b0;
    cyc(40);
    // Back to grounded static expander, then a second reset
    mode     <= 1'b0;
    hold_low <= 1'b1;
    src      <= 1'b1;
    osc      <= 1'b0;
    resetn   <= 1'b0;
    cyc(10);
    resetn <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, `LSD_A_STATUS, 32'h0, 33'h84);
    check(seg, 64'h0);
    conclude();
  end
endmodule : tb_top
